// File: include/uart_irq_regs.vh
// Register offsets, field positions, codes and reset values for the serial port control block.
`ifndef UART_IRQ_REGS_VH
`define UART_IRQ_REGS_VH
`define PORT0_IRQ_IDENTIFY_ADDR 8'hC2
`define PORT0_QUEUE_CONTROL_ADDR 8'hC2
`define PORT1_IRQ_IDENTIFY_ADDR 8'hD2
`define PORT1_QUEUE_CONTROL_ADDR 8'hD2
`define TX_HOLD_ADDR_P0 8'hC0
`define TX_HOLD_ADDR_P1 8'hD0
`define RX_BUF_ADDR_P0 8'hC0
`define RX_BUF_ADDR_P1 8'hD0
`define QCTL_RESET 8'h00
`define QCTL_ON_BIT 0
`define QCTL_RX_FLUSH_BIT 1
`define QCTL_TX_FLUSH_BIT 2
`define QCTL_LEVEL_HI 7
`define QCTL_LEVEL_LO 6
`define CAUSE_LINE_STATUS 3'h3
`define CAUSE_RX_DATA 3'h2
`define CAUSE_TIMEOUT 3'h6
`define CAUSE_TX_EMPTY 3'h1
`define CAUSE_MODEM 3'h0
`define LEVEL_SEL0 5'h01
`define LEVEL_SEL1 5'h04
`define LEVEL_SEL2 5'h08
`define LEVEL_SEL3 5'h0E
`define QUEUE_DEPTH 16
`define QUEUE_AW 4
`define UNBUFFERED_DEPTH 5'h01
`endif

// File: design/uart_byte_queue.v
// Byte queue with flush and a depth limit that shrinks to one entry when queueing is off.
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_regs.vh"
module uart_byte_queue #(
  parameter DEPTH = `QUEUE_DEPTH,
  parameter AW = `QUEUE_AW,
  parameter WIDTH = 8
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire flush_i,
  input wire queue_on_i,
  input wire push_i,
  input wire [WIDTH-1:0] push_data_i,
  output wire push_ready_o,
  input wire pop_i,
  output reg [WIDTH-1:0] pop_data_o,
  output wire pop_valid_o,
  output reg [AW:0] count_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  wire [AW:0] limit;
  wire do_push;
  wire do_pop;
  // ------------------------------------------------------------
  // Capacity follows the enable: one byte when off, full depth when on.
  // ------------------------------------------------------------
  assign limit = queue_on_i ? DEPTH[AW:0] : `UNBUFFERED_DEPTH;
  assign push_ready_o = (count_o < limit);
  assign pop_valid_o = (count_o != {(AW+1){1'b0}});
  assign do_push = push_i && push_ready_o && !flush_i;
  assign do_pop = pop_i && pop_valid_o && !flush_i;
  // Pointer and count update; flush has priority so no stale byte survives.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count_o <= {(AW+1){1'b0}};
    end else if (flush_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count_o <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_o <= count_o + 1'b1;
      end else if (do_pop && !do_push) begin
        count_o <= count_o - 1'b1;
      end
    end
  end
  // Storage has no reset; the count guards every pop, but the head register reads it every cycle.
  always @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_i;
    end
  end
  // Registered head of queue for the consumer.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pop_data_o <= {WIDTH{1'b0}};
    end else begin
      pop_data_o <= mem[rd_ptr];
    end
  end
endmodule // uart_byte_queue
`default_nettype wire

// File: design/uart_irq_prio.v
// Priority encoder that turns enabled interrupt sources into one cause code.
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_regs.vh"
module uart_irq_prio (
  input wire line_status_i,
  input wire rx_data_i,
  input wire timeout_i,
  input wire tx_empty_i,
  input wire modem_i,
  output reg [2:0] cause_o,
  output wire any_o
);
  assign any_o = line_status_i | rx_data_i | timeout_i | tx_empty_i | modem_i;
  // ------------------------------------------------------------
  // Only the highest active source is shown; lower ones wait.
  // ------------------------------------------------------------
  always @* begin
    if (line_status_i) begin
      cause_o = `CAUSE_LINE_STATUS;
    end else if (rx_data_i) begin
      cause_o = `CAUSE_RX_DATA;
    end else if (timeout_i) begin
      cause_o = `CAUSE_TIMEOUT;
    end else if (tx_empty_i) begin
      cause_o = `CAUSE_TX_EMPTY;
    end else begin
      cause_o = `CAUSE_MODEM; // Also shown when idle; the pending flag qualifies it.
    end
  end
endmodule // uart_irq_prio
`default_nettype wire

// File: design/uart_irq_id_and_fifo_ctrl.v
// Interrupt identification and queue control for one serial port.
`timescale 1ns/1ps
`default_nettype none
`include "uart_irq_regs.vh"
module uart_irq_id_and_fifo_ctrl #(
  parameter [7:0] IDENT_ADDR = `PORT0_IRQ_IDENTIFY_ADDR,
  parameter [7:0] DATA_ADDR = `TX_HOLD_ADDR_P0,
  parameter ERR_WIDTH = 3
) (
  input wire CLK_SYS_I,
  input wire RST_B_I,
  input wire [7:0] ADDR_I,
  input wire [7:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [7:0] RDATA_O,
  input wire IER_LINE_I,
  input wire IER_TX_I,
  input wire IER_RX_I,
  input wire IER_MODEM_I,
  input wire LINE_STATUS_I,
  input wire TIMEOUT_I,
  input wire MODEM_I,
  input wire RX_PUSH_I,
  input wire [7:0] RX_DATA_I,
  input wire [ERR_WIDTH-1:0] RX_ERR_I,
  output wire RX_READY_O,
  output wire [ERR_WIDTH-1:0] RX_HEAD_ERR_O,
  input wire TX_POP_I,
  output wire [7:0] TX_DATA_O,
  output wire TX_VALID_O,
  output wire IRQ_O,
  output wire QUEUE_ON_O,
  output wire [4:0] RX_COUNT_O,
  output wire [4:0] TX_COUNT_O
);
  // ------------------------------------------------------------
  // Decoding helpers.
  // ------------------------------------------------------------
  // Level code to byte threshold.
  function [4:0] level_bytes;
    input [1:0] sel;
    begin
      if (sel == 2'h0) begin
        level_bytes = `LEVEL_SEL0;
      end else if (sel == 2'h1) begin
        level_bytes = `LEVEL_SEL1;
      end else if (sel == 2'h2) begin
        level_bytes = `LEVEL_SEL2;
      end else begin
        level_bytes = `LEVEL_SEL3;
      end
    end
  endfunction
  // Address match used by several strobes.
  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  reg queue_on;
  reg [1:0] rx_level_select;
  reg tx_queue_flush;
  reg rx_queue_flush;
  wire ctl_wr;
  wire id_rd;
  wire data_wr;
  wire data_rd;
  wire [4:0] rx_count;
  wire [4:0] tx_count;
  wire rx_valid;
  wire [7:0] rx_head;
  wire [ERR_WIDTH-1:0] err_head;
  wire tx_ready;
  wire rx_data_event;
  wire [2:0] irq_cause_code;
  wire any_irq;
  wire irq_pending_n;
  wire [7:0] irq_identify_reg;
  wire [1:0] queue_state;
  // ------------------------------------------------------------
  // Address decode: one address, direction picks the register.
  // ------------------------------------------------------------
  assign ctl_wr = WR_I && hit(ADDR_I, IDENT_ADDR);
  assign id_rd = RD_I && hit(ADDR_I, IDENT_ADDR);
  assign data_wr = WR_I && hit(ADDR_I, DATA_ADDR);
  assign data_rd = RD_I && hit(ADDR_I, DATA_ADDR);

  // Control write: enable and level stored, flush bits are one-cycle strobes.
  // Flushes are gated by the enable being written, so enabling and flushing together works.
  always @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      queue_on <= 1'b0;
      rx_level_select <= 2'h0;
      tx_queue_flush <= 1'b0;
      rx_queue_flush <= 1'b0;
    end else begin
      tx_queue_flush <= 1'b0;
      rx_queue_flush <= 1'b0;
      if (ctl_wr) begin
        queue_on <= WDATA_I[`QCTL_ON_BIT];
        rx_level_select <= WDATA_I[`QCTL_LEVEL_HI:`QCTL_LEVEL_LO];
        rx_queue_flush <= WDATA_I[`QCTL_RX_FLUSH_BIT] & WDATA_I[`QCTL_ON_BIT];
        tx_queue_flush <= WDATA_I[`QCTL_TX_FLUSH_BIT] & WDATA_I[`QCTL_ON_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // Queues: receive data and its error flags share one pointer pair.
  // ------------------------------------------------------------
  uart_byte_queue #(
    .DEPTH(`QUEUE_DEPTH),
    .AW(`QUEUE_AW),
    .WIDTH(8 + ERR_WIDTH)
  ) u_rx_queue (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .flush_i(rx_queue_flush),
    .queue_on_i(queue_on),
    .push_i(RX_PUSH_I),
    .push_data_i({RX_ERR_I, RX_DATA_I}),
    .push_ready_o(RX_READY_O),
    .pop_i(data_rd),
    .pop_data_o({err_head, rx_head}),
    .pop_valid_o(rx_valid),
    .count_o(rx_count)
  );

  uart_byte_queue #(
    .DEPTH(`QUEUE_DEPTH),
    .AW(`QUEUE_AW),
    .WIDTH(8)
  ) u_tx_queue (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .flush_i(tx_queue_flush),
    .queue_on_i(queue_on),
    .push_i(data_wr),
    .push_data_i(WDATA_I),
    .push_ready_o(tx_ready),
    .pop_i(TX_POP_I),
    .pop_data_o(TX_DATA_O),
    .pop_valid_o(TX_VALID_O),
    .count_o(tx_count)
  );

  assign RX_HEAD_ERR_O = err_head;
  assign RX_COUNT_O = rx_count;
  assign TX_COUNT_O = tx_count;
  assign QUEUE_ON_O = queue_on;

  // ------------------------------------------------------------
  // Interrupt sources and identification.
  // ------------------------------------------------------------
  // Receive threshold only applies with queueing on; off, any byte counts.
  assign rx_data_event = queue_on ? (rx_count >= level_bytes(rx_level_select)) : rx_valid;

  uart_irq_prio u_prio (
    .line_status_i(LINE_STATUS_I & IER_LINE_I),
    .rx_data_i(rx_data_event & IER_RX_I),
    .timeout_i(TIMEOUT_I & IER_RX_I),
    .tx_empty_i(!TX_VALID_O & IER_TX_I),
    .modem_i(MODEM_I & IER_MODEM_I),
    .cause_o(irq_cause_code),
    .any_o(any_irq)
  );

  assign irq_pending_n = !any_irq;
  assign queue_state = queue_on ? 2'h3 : 2'h0;
  // Cause is forced to zero when nothing pends so software never sees a stale code.
  assign irq_identify_reg = {queue_state, 2'h0, (any_irq ? irq_cause_code : 3'h0), irq_pending_n};
  assign IRQ_O = any_irq;

  // Registered read data; unmapped addresses read zero.
  always @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RDATA_O <= 8'h00;
    end else if (id_rd) begin
      RDATA_O <= irq_identify_reg;
    end else if (data_rd) begin
      RDATA_O <= rx_head;
    end else begin
      RDATA_O <= 8'h00;
    end
  end
endmodule // uart_irq_id_and_fifo_ctrl
`default_nettype wire

// File: bench/irq_ctrl_props.sv
// Concurrent checks on the identify and queue control ports.
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_props (
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic IER_LINE_I,
  input wire logic IER_RX_I,
  input wire logic LINE_STATUS_I,
  input wire logic TIMEOUT_I,
  input wire logic TX_POP_I,
  input wire logic IRQ_O,
  input wire logic QUEUE_ON_O,
  input wire logic [4:0] RX_COUNT_O,
  input wire logic [4:0] TX_COUNT_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RST_B_I);
  // Decoded accesses; identify and control share one address.
  wire rd_id = RD_I && ADDR_I == 8'hC2;
  wire wr_ctl = WR_I && ADDR_I == 8'hC2;
  wire wr_tx = WR_I && ADDR_I == 8'hC0;
  sequence s_flush_rx;
    wr_ctl && WDATA_I[1] && WDATA_I[0];
  endsequence
  sequence s_flush_tx;
    wr_ctl && WDATA_I[2] && WDATA_I[0];
  endsequence
  a_pend_bit: assert property (rd_id |=> RDATA_O[0] == !$past(IRQ_O))
    else $error("Pending bit wrong.");
  a_state_bits: assert property (rd_id |=> RDATA_O[7:4] == {{2{$past(QUEUE_ON_O)}}, 2'b00})
    else $error("Queue state bits wrong.");
  a_read_idle: assert property (!RD_I |=> RDATA_O == 8'h00)
    else $error("Read data not cleared.");
  a_cause_idle: assert property (rd_id && !IRQ_O |=> RDATA_O[3:1] == 3'h0)
    else $error("Cause set with nothing pending.");
  a_line_first: assert property (rd_id && LINE_STATUS_I && IER_LINE_I |=> RDATA_O[3:0] == 4'h6)
    else $error("Line status not on top.");
  a_timeout_code: assert property (rd_id && IER_RX_I && TIMEOUT_I && !(IER_LINE_I && LINE_STATUS_I)
    && RX_COUNT_O == 5'h00 |=> RDATA_O[3:0] == 4'hC)
    else $error("Timeout code wrong.");
  a_queue_on: assert property (wr_ctl |=> QUEUE_ON_O == $past(WDATA_I[0]))
    else $error("Queue enable not taken.");
  a_rx_flush: assert property (s_flush_rx |-> ##[2:3] RX_COUNT_O == 5'h00)
    else $error("Receive flush failed.");
  a_tx_flush: assert property (s_flush_tx |-> ##[2:3] TX_COUNT_O == 5'h00)
    else $error("Transmit flush failed.");
  a_tx_full: assert property (wr_tx && QUEUE_ON_O && TX_COUNT_O == 5'h10 |=> TX_COUNT_O == 5'h10)
    else $error("Full queue grew.");
  a_tx_single: assert property (wr_tx && !QUEUE_ON_O && TX_COUNT_O != 5'h00 && !TX_POP_I
    |=> TX_COUNT_O == $past(TX_COUNT_O))
    else $error("Single buffer overfilled.");
endmodule // irq_ctrl_props
bind uart_irq_id_and_fifo_ctrl irq_ctrl_props props_u (.*);
`default_nettype wire

// File: bench/uart_line_model.sv
// Line-side model that feeds received bytes and drains the transmit queue.
`timescale 1ns/1ps
`default_nettype none
module uart_line_model (
  input wire logic clk_i,
  input wire logic tx_valid_i,
  output logic rx_push_o,
  output logic [7:0] rx_data_o,
  output logic [2:0] rx_err_o,
  output logic tx_pop_o
);
  // Idle values; data shows the inverse after a push so a stale byte never passes.
  initial begin
    rx_push_o = 1'b0;
    rx_data_o = 8'h00;
    rx_err_o = 3'h0;
    tx_pop_o = 1'b0;
  end
  task automatic send(input logic [7:0] d);
    @(posedge clk_i);
    rx_push_o <= 1'b1;
    rx_data_o <= d;
    @(posedge clk_i);
    rx_push_o <= 1'b0;
    rx_data_o <= ~d;
  endtask
  // A real transmitter only pops when a byte is waiting.
  task automatic take();
    @(posedge clk_i);
    tx_pop_o <= tx_valid_i;
    @(posedge clk_i);
    tx_pop_o <= 1'b0;
  endtask
endmodule // uart_line_model
`default_nettype wire

// File: bench/uart_irq_id_and_fifo_ctrl_bench.sv
// Self-checking bench for the identify and queue control block.
`timescale 1ns/1ps
`default_nettype none
module uart_irq_id_and_fifo_ctrl_bench;
  logic CLK_SYS_I = 0, RST_B_I = 0, WR_I = 0, RD_I = 0;
  logic [7:0] ADDR_I = 8'h00, WDATA_I = 8'h00;
  logic IER_LINE_I = 0, IER_TX_I = 0, IER_RX_I = 0, IER_MODEM_I = 0;
  logic LINE_STATUS_I = 0, TIMEOUT_I = 0, MODEM_I = 0;
  logic RX_PUSH_I, TX_POP_I, RX_READY_O, TX_VALID_O, IRQ_O, QUEUE_ON_O;
  logic [7:0] RX_DATA_I, RDATA_O, TX_DATA_O;
  logic [2:0] RX_ERR_I, RX_HEAD_ERR_O;
  logic [4:0] RX_COUNT_O, TX_COUNT_O;
  int err_count = 0, cmp_count = 0;
  int lv[4] = '{1, 4, 8, 14};
  always #2.5 CLK_SYS_I = ~CLK_SYS_I;
  uart_irq_id_and_fifo_ctrl dut_u (.*);
  uart_line_model line_u (.clk_i(CLK_SYS_I), .tx_valid_i(TX_VALID_O), .rx_push_o(RX_PUSH_I),
    .rx_data_o(RX_DATA_I), .rx_err_o(RX_ERR_I), .tx_pop_o(TX_POP_I));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS_I);
    {ADDR_I, WDATA_I, WR_I} <= {a, d, 1'b1};
    @(posedge CLK_SYS_I);
    WR_I <= 1'b0;
  endtask
  // Read data is registered, so it is looked at just after the sampling edge.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK_SYS_I);
    {ADDR_I, RD_I} <= {a, 1'b1};
    @(posedge CLK_SYS_I);
    RD_I <= 1'b0;
    #1 chk(RDATA_O, e);
  endtask
  task automatic src(input logic l, input logic t, input logic m);
    @(posedge CLK_SYS_I);
    {LINE_STATUS_I, TIMEOUT_I, MODEM_I} <= {l, t, m};
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard: an expired limit counts as a mismatch.
  initial begin
    repeat (20000) @(posedge CLK_SYS_I);
    err_count++;
    report_and_stop();
  end
  // Priority cascade, trigger levels, then queue depth and flushes.
  initial begin
    repeat (2) @(posedge CLK_SYS_I);
    RST_B_I <= 1'b1;
    rd(8'hC2, 8'h01);
    @(posedge CLK_SYS_I);
    {IER_LINE_I, IER_TX_I, IER_RX_I, IER_MODEM_I} <= 4'hF;
    src(1, 1, 1);
    line_u.send(8'h3C);
    rd(8'hC2, 8'h06);
    chk({7'h00, IRQ_O}, 8'h01);
    src(0, 1, 1);
    rd(8'hC2, 8'h04);
    rd(8'hC0, 8'h3C);
    rd(8'hC2, 8'h0C);
    src(0, 0, 1);
    rd(8'hC2, 8'h02);
    wr(8'hC0, 8'h11);
    rd(8'hC2, 8'h00);
    src(0, 0, 0);
    rd(8'hC2, 8'h01);
    chk(TX_DATA_O, 8'h11);
    line_u.take();
    {IER_LINE_I, IER_TX_I, IER_RX_I, IER_MODEM_I} <= 4'h2;
    for (int i = 0; i < 4; i++) begin
      wr(8'hC2, {i[1:0], 6'h03});
      repeat (2) @(posedge CLK_SYS_I);
      #1 chk({3'h0, RX_COUNT_O}, 8'h00);
      repeat (lv[i] - 1) line_u.send(8'h40 + i[7:0]);
      rd(8'hC2, 8'hC1);
      line_u.send(8'h5A);
      rd(8'hC2, 8'hC4);
    end
    @(posedge CLK_SYS_I);
    {IER_LINE_I, IER_TX_I, IER_RX_I, IER_MODEM_I} <= 4'h0;
    wr(8'hC2, 8'h01);
    repeat (17) wr(8'hC0, 8'h77);
    #1 chk({3'h0, TX_COUNT_O}, 8'h10);
    wr(8'hC2, 8'h05);
    repeat (2) @(posedge CLK_SYS_I);
    #1 chk({3'h0, TX_COUNT_O}, 8'h00);
    chk({3'h0, RX_COUNT_O}, 8'h0E);
    wr(8'hC2, 8'h00);
    rd(8'hC2, 8'h01);
    wr(8'hC0, 8'hA5);
    wr(8'hC0, 8'h5A);
    #1 chk({3'h0, TX_COUNT_O}, 8'h01);
    wr(8'hC2, 8'h06);
    repeat (2) @(posedge CLK_SYS_I);
    #1 chk({3'h0, TX_COUNT_O}, 8'h01);
    chk({3'h0, RX_COUNT_O}, 8'h0E);
    chk(TX_DATA_O, 8'hA5);
    chk({7'h00, TX_VALID_O}, 8'h01);
    chk({7'h00, RX_READY_O}, 8'h00);
    chk({5'h00, RX_HEAD_ERR_O}, 8'h00);
    chk({7'h00, IRQ_O}, 8'h00);
    rd(8'hC5, 8'h00);
    report_and_stop();
  end
endmodule // uart_irq_id_and_fifo_ctrl_bench
`default_nettype wire
